// File: hw/slp_sched.sv
// Power state controller and I/O sample scheduler with an APB slave.
// Assumes one 250 MHz clock, a host-driven sleep request pin and
// one-cycle event pulses from the radio and serial logic.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "slp_sched_regs.svh"
module slp_sched
    import slp_sched_pkg::*;
#(
    parameter int MS_CYCLES = `SLP_MS_CYCLES,
    parameter int DIO_W = 13
) (
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_SYS_RST,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [`SLP_ADDR_W-1:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // Pins
    input wire logic I_SLEEP_REQUEST_PIN,
    input wire logic [DIO_W-1:0] I_DIO,
    output logic O_AWAKE,
    output logic O_CTS_N,
    // Radio and serial events
    input wire logic I_BUSY,
    input wire logic I_SER_RX,
    input wire logic I_RF_RX,
    input wire logic I_SYNC_RX,
    input wire logic I_SYNC_FROM_SLEEPER,
    input wire logic [15:0] I_SYNC_SLEEP_MS,
    input wire logic [15:0] I_SYNC_WAKE_MS,
    input wire logic I_JOIN_REQ,
    input wire logic I_SAMPLE_RX,
    // Power and traffic control
    output logic O_SLEEPING,
    output logic O_RX_EN,
    output logic O_DATA_TX_OK,
    output logic O_ROUTE_OK,
    // Event pulses
    output logic O_SYNC_TX,
    output logic O_SYNC_RELAY,
    output logic O_SYNC_POLL,
    output logic O_SAMPLE_REQ,
    output logic O_SAMPLE_CHG,
    output logic O_SAMPLE_FWD,
    output logic O_SAMPLE_DROP
);

    localparam int TW = $clog2(MS_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(MS_CYCLES - 1);

    generate
        if (MS_CYCLES < 1 || DIO_W < 1 || DIO_W > 16) begin : g_bad
            $error("slp_sched: unsupported parameter values");
        end
    endgenerate

    // Modes whose power state is run by the wake and sleep timers.
    function automatic logic is_timed(input logic [3:0] m);
        return m == MODE_CYCLIC || m == MODE_CYC_PIN ||
            m == MODE_SUPPORT || m == MODE_SYNC_CYC;
    endfunction

    // Modes that track the synchronous network schedule.
    function automatic logic is_sync(input logic [3:0] m);
        return m == MODE_NORMAL || m == MODE_SUPPORT ||
            m == MODE_SYNC_CYC;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Configuration registers
    ////////////////////////////////////////////////////////////////////

    logic [3:0] mode_q;
    logic flow_en_q;
    logic awake_en_q;
    logic api_en_q;
    logic coord_q;
    logic [15:0] wake_set_q;
    logic [15:0] sleep_set_q;
    logic [15:0] ival_q;
    logic [DIO_W-1:0] mask_q;
    logic [31:0] rdata_q;

    wire apb_setup = I_PSEL && !I_PENABLE;
    wire apb_wr = I_PSEL && I_PENABLE && I_PWRITE;
    wire sel_ctrl = I_PADDR == `SLP_ADDR_CTRL;
    wire sel_wake = I_PADDR == `SLP_ADDR_WAKE;
    wire sel_sleep = I_PADDR == `SLP_ADDR_SLEEP;
    wire sel_ival = I_PADDR == `SLP_ADDR_IVAL;
    wire sel_mask = I_PADDR == `SLP_ADDR_MASK;
    wire sel_stat = I_PADDR == `SLP_ADDR_STAT;
    wire sel_nslp = I_PADDR == `SLP_ADDR_NSLP;
    wire sel_nwak = I_PADDR == `SLP_ADDR_NWAK;
    wire sel_any = sel_ctrl || sel_wake || sel_sleep || sel_ival ||
        sel_mask || sel_stat || sel_nslp || sel_nwak;

    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            mode_q <= `SLP_RST_MODE;
            flow_en_q <= `SLP_RST_CTRL_BIT;
            awake_en_q <= `SLP_RST_CTRL_BIT;
            api_en_q <= `SLP_RST_CTRL_BIT;
            coord_q <= `SLP_RST_CTRL_BIT;
        end else if (apb_wr && sel_ctrl) begin
            mode_q <= I_PWDATA[`SLP_CTRL_MODE_LSB +: `SLP_CTRL_MODE_W];
            flow_en_q <= I_PWDATA[`SLP_CTRL_FLOW_BIT];
            awake_en_q <= I_PWDATA[`SLP_CTRL_AWAKE_BIT];
            api_en_q <= I_PWDATA[`SLP_CTRL_API_BIT];
            coord_q <= I_PWDATA[`SLP_CTRL_COORD_BIT];
        end
    end

    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            wake_set_q <= `SLP_RST_WAKE;
            sleep_set_q <= `SLP_RST_SLEEP;
            ival_q <= `SLP_RST_IVAL;
            mask_q <= DIO_W'(`SLP_RST_MASK);
        end else if (apb_wr) begin
            if (sel_wake) wake_set_q <= I_PWDATA[15:0];
            if (sel_sleep) sleep_set_q <= I_PWDATA[15:0];
            if (sel_ival) ival_q <= I_PWDATA[15:0];
            if (sel_mask) mask_q <= I_PWDATA[DIO_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pins, millisecond tick and synchronisation state
    ////////////////////////////////////////////////////////////////////

    logic rq_s;
    logic [DIO_W-1:0] dio_s;

    slp_pin_sync #(.W(1 + DIO_W)) i_slp_pin_sync (
        .i_clk(I_SYS_CLK),
        .i_rst(I_SYS_RST),
        .i_pin({I_SLEEP_REQUEST_PIN, I_DIO}),
        .o_level({rq_s, dio_s})
    );

    logic [TW-1:0] tick_cnt_q;
    wire ms_tick = tick_cnt_q == TICK_LAST;

    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) tick_cnt_q <= '0;
        else tick_cnt_q <= ms_tick ? '0 : tick_cnt_q + 1'b1;
    end

    pwr_state_t state_q;
    pwr_state_t state_d;
    logic synced_q;
    logic [15:0] net_sleep_q;
    logic [15:0] net_wake_q;

    wire asleep = state_q == ST_SLEEP;
    wire sync_take = I_SYNC_RX && is_sync(mode_q) && !asleep;

    // Synchronised nodes run on the network's times; the local
    // settings only carry an unsynchronised node to its first sync.
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            synced_q <= 1'b0;
            net_sleep_q <= '0;
            net_wake_q <= '0;
        end else if (sync_take) begin
            synced_q <= 1'b1;
            net_sleep_q <= I_SYNC_SLEEP_MS;
            net_wake_q <= I_SYNC_WAKE_MS;
        end else if (!is_sync(mode_q)) begin
            synced_q <= 1'b0;
        end
    end

    wire use_net = synced_q && is_sync(mode_q);
    wire [15:0] wake_len = use_net ? net_wake_q : wake_set_q;
    wire [15:0] sleep_len = use_net ? net_sleep_q : sleep_set_q;

    ////////////////////////////////////////////////////////////////////
    // Power state machine and timers
    ////////////////////////////////////////////////////////////////////

    logic [15:0] wake_cnt_q;
    logic [15:0] sleep_cnt_q;

    wire async_cyc = mode_q == MODE_CYCLIC || mode_q == MODE_CYC_PIN;
    wire pin_hold = mode_q == MODE_CYC_PIN && !rq_s;
    wire data_evt = (I_SER_RX || I_RF_RX) && !asleep;
    wire wake_start = asleep && state_d == ST_ACTIVE;
    wire sleep_start = state_q == ST_DRAIN && state_d == ST_SLEEP;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_ACTIVE: begin
                if (mode_q == MODE_PIN && rq_s) begin
                    state_d = ST_DRAIN;
                end else if (is_timed(mode_q) && !pin_hold &&
                    wake_cnt_q == '0 && !data_evt) begin
                    state_d = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (mode_q == MODE_PIN && !rq_s) begin
                    state_d = ST_ACTIVE;
                end else if (!(is_timed(mode_q) || mode_q == MODE_PIN) ||
                    pin_hold || (async_cyc && data_evt)) begin
                    state_d = ST_ACTIVE;
                end else if (!I_BUSY) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (mode_q == MODE_PIN) begin
                    if (!rq_s) state_d = ST_ACTIVE;
                end else if (pin_hold) begin
                    state_d = ST_ACTIVE;
                end else if (!is_timed(mode_q)) begin
                    state_d = ST_ACTIVE;
                end else if (sleep_cnt_q == '0) begin
                    state_d = ST_ACTIVE;
                end
            end
            default: state_d = ST_ACTIVE;
        endcase
    end

    // Asynchronous cyclic wakes only for a poll; synchronous modes wake
    // for the full wake time.
    wire [15:0] wake_load = async_cyc ? `SLP_POLL_MS : wake_len;

    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            state_q <= ST_ACTIVE;
            wake_cnt_q <= '0;
            sleep_cnt_q <= '0;
        end else begin
            state_q <= state_d;
            if (async_cyc && data_evt) begin
                wake_cnt_q <= wake_set_q;
            end else if (sync_take && mode_q != MODE_NORMAL) begin
                wake_cnt_q <= I_SYNC_WAKE_MS;
            end else if (wake_start) begin
                wake_cnt_q <= wake_load;
            end else if (ms_tick && wake_cnt_q != '0 && !asleep) begin
                wake_cnt_q <= wake_cnt_q - 1'b1;
            end
            if (sleep_start) begin
                sleep_cnt_q <= sleep_len;
            end else if (ms_tick && sleep_cnt_q != '0 && asleep) begin
                sleep_cnt_q <= sleep_cnt_q - 1'b1;
            end
        end
    end

    // Support nodes walk the schedule to know when the network is awake,
    // but stay powered throughout.
    wire low_power = asleep && mode_q != MODE_SUPPORT;
    wire net_awake = !asleep;

    assign O_SLEEPING = low_power;
    assign O_RX_EN = !low_power;
    assign O_AWAKE = mode_q == MODE_SYNC_CYC ?
        (awake_en_q && !low_power) : !low_power;
    assign O_CTS_N = flow_en_q && low_power;
    assign O_ROUTE_OK = mode_q == MODE_NORMAL || net_awake;
    assign O_DATA_TX_OK = mode_q != MODE_SUPPORT || net_awake;

    ////////////////////////////////////////////////////////////////////
    // Sync messages and I/O sampling
    ////////////////////////////////////////////////////////////////////

    logic sync_tx_q;
    logic relay_q;
    logic poll_q;
    logic smp_req_q;
    logic smp_chg_q;
    logic fwd_q;
    logic drop_q;
    logic [15:0] ival_cnt_q;
    logic [DIO_W-1:0] dio_prev_q;

    wire can_lead = coord_q && (mode_q == MODE_SUPPORT ||
        mode_q == MODE_SYNC_CYC);
    wire sync_lead = can_lead && wake_start;
    wire sync_join = mode_q == MODE_SUPPORT && synced_q && I_JOIN_REQ;
    wire relay_ok = sync_take && (mode_q != MODE_NORMAL ||
        I_SYNC_FROM_SLEEPER);
    wire poll_now = wake_start && mode_q == MODE_SYNC_CYC &&
        !synced_q && !coord_q;
    wire ival_hit = ival_q != '0 && ms_tick &&
        ival_cnt_q + 16'h0001 >= ival_q;
    wire chg_hit = |((dio_s ^ dio_prev_q) & mask_q);

    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            ival_cnt_q <= '0;
            dio_prev_q <= '0;
        end else begin
            dio_prev_q <= dio_s;
            if (ival_q == '0 || low_power || ival_hit) begin
                ival_cnt_q <= '0;
            end else if (ms_tick) begin
                ival_cnt_q <= ival_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            sync_tx_q <= 1'b0;
            relay_q <= 1'b0;
            poll_q <= 1'b0;
            smp_req_q <= 1'b0;
            smp_chg_q <= 1'b0;
            fwd_q <= 1'b0;
            drop_q <= 1'b0;
        end else begin
            sync_tx_q <= sync_lead || sync_join;
            relay_q <= relay_ok;
            poll_q <= poll_now;
            smp_req_q <= ival_hit && !low_power;
            smp_chg_q <= chg_hit && !low_power;
            fwd_q <= I_SAMPLE_RX && api_en_q;
            drop_q <= I_SAMPLE_RX && !api_en_q;
        end
    end

    assign O_SYNC_TX = sync_tx_q;
    assign O_SYNC_RELAY = relay_q;
    assign O_SYNC_POLL = poll_q;
    assign O_SAMPLE_REQ = smp_req_q;
    assign O_SAMPLE_CHG = smp_chg_q;
    assign O_SAMPLE_FWD = fwd_q;
    assign O_SAMPLE_DROP = drop_q;

    ////////////////////////////////////////////////////////////////////
    // APB read path
    ////////////////////////////////////////////////////////////////////

    wire [31:0] ctrl_rd = {24'h000000, coord_q, api_en_q, awake_en_q,
        flow_en_q, mode_q};
    wire [31:0] stat_rd = {27'h0000000, rq_s, state_q, synced_q,
        !low_power};
    wire [31:0] rd_mux =
        sel_ctrl ? ctrl_rd :
        sel_wake ? {16'h0000, wake_set_q} :
        sel_sleep ? {16'h0000, sleep_set_q} :
        sel_ival ? {16'h0000, ival_q} :
        sel_mask ? {{(32 - DIO_W){1'b0}}, mask_q} :
        sel_stat ? stat_rd :
        sel_nslp ? {16'h0000, net_sleep_q} :
        sel_nwak ? {16'h0000, net_wake_q} : 32'h00000000;

    // Read data is captured in the setup phase so the access phase
    // completes without wait states.
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) rdata_q <= '0;
        else if (apb_setup) rdata_q <= rd_mux;
    end

    assign O_PRDATA = rdata_q;
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = I_PSEL && I_PENABLE && !sel_any;

    ////////////////////////////////////////////////////////////////////
    // Assertions
    ////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SYS_RST);

    property p_normal_awake;
        mode_q == MODE_NORMAL [*2] |-> !O_SLEEPING;
    endproperty
    a_normal_awake: assert property (p_normal_awake)
        else $error("normal mode in low power");

    property p_drain;
        state_q == ST_DRAIN && I_BUSY |=> state_q != ST_SLEEP;
    endproperty
    a_drain: assert property (p_drain)
        else $error("slept during a transfer");

    property p_pin_wake;
        mode_q == MODE_PIN && asleep && !rq_s |=> !O_SLEEPING && O_AWAKE;
    endproperty
    a_pin_wake: assert property (p_pin_wake)
        else $error("pin low did not wake");

    property p_cts;
        flow_en_q && O_SLEEPING |-> O_CTS_N && !O_AWAKE;
    endproperty
    a_cts: assert property (p_cts)
        else $error("flow or awake pin wrong while asleep");

    property p_hold;
        pin_hold && !asleep |=> !asleep;
    endproperty
    a_hold: assert property (p_hold)
        else $error("slept with request pin low");

    property p_restart;
        async_cyc && data_evt |=> wake_cnt_q == $past(wake_set_q) &&
            state_q == ST_ACTIVE;
    endproperty
    a_restart: assert property (p_restart)
        else $error("wake timer not restarted");

    property p_support;
        mode_q == MODE_SUPPORT [*2] |-> !O_SLEEPING ##0 O_RX_EN;
    endproperty
    a_support: assert property (p_support)
        else $error("support node slept");

    property p_no_rx;
        mode_q == MODE_SYNC_CYC && asleep |-> !O_RX_EN;
    endproperty
    a_no_rx: assert property (p_no_rx)
        else $error("receive open while asleep");

    property p_one_sync;
        O_SYNC_TX && mode_q == MODE_SYNC_CYC |=> !O_SYNC_TX [*2];
    endproperty
    a_one_sync: assert property (p_one_sync)
        else $error("more than one sync per wake");

    property p_ival_off;
        ival_q == '0 [*2] |-> !O_SAMPLE_REQ;
    endproperty
    a_ival_off: assert property (p_ival_off)
        else $error("sample with zero interval");

    property p_fwd;
        I_SAMPLE_RX |=> O_SAMPLE_FWD == $past(api_en_q) &&
            O_SAMPLE_DROP == !$past(api_en_q);
    endproperty
    a_fwd: assert property (p_fwd)
        else $error("received sample routed wrongly");

    c_pin_cycle: cover property (mode_q == MODE_PIN && asleep ##[1:50]
        !asleep);
    c_cyc_extend: cover property (async_cyc && data_evt ##1
        state_q == ST_ACTIVE);
    c_sync_take: cover property (mode_q == MODE_SYNC_CYC && sync_take);
    c_change: cover property (O_SAMPLE_CHG);

endmodule // slp_sched
`default_nettype wire

// File: hw/slp_sched_regs.svh
// Register offsets, field positions, reset values and timing counts
// of the sleep and sample scheduler.
// Assumes a 32-bit APB slave with byte addresses and aligned words.
`ifndef SLP_SCHED_REGS_SVH
`define SLP_SCHED_REGS_SVH

`define SLP_ADDR_W 8
`define SLP_ADDR_CTRL 8'h00
`define SLP_ADDR_WAKE 8'h04
`define SLP_ADDR_SLEEP 8'h08
`define SLP_ADDR_IVAL 8'h0C
`define SLP_ADDR_MASK 8'h10
`define SLP_ADDR_STAT 8'h14
`define SLP_ADDR_NSLP 8'h18
`define SLP_ADDR_NWAK 8'h1C

`define SLP_CTRL_MODE_LSB 0
`define SLP_CTRL_MODE_W 4
`define SLP_CTRL_FLOW_BIT 4
`define SLP_CTRL_AWAKE_BIT 5
`define SLP_CTRL_API_BIT 6
`define SLP_CTRL_COORD_BIT 7

`define SLP_STAT_AWAKE_BIT 0
`define SLP_STAT_SYNC_BIT 1
`define SLP_STAT_STATE_LSB 2
`define SLP_STAT_RQ_BIT 4

`define SLP_RST_MODE 4'h0
`define SLP_RST_WAKE 16'h0064
`define SLP_RST_SLEEP 16'h00C8
`define SLP_RST_IVAL 16'h0000
`define SLP_RST_MASK 13'h0000
`define SLP_RST_CTRL_BIT 1'b0

`define SLP_CLK_NS 4
`define SLP_MS_NS 1000000
`define SLP_MS_CYCLES (`SLP_MS_NS / `SLP_CLK_NS)
`define SLP_POLL_MS 16'h0000

`endif

// File: hw/slp_sched_pkg.sv
// Types shared by the sleep and sample scheduler.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package slp_sched_pkg;

    typedef enum logic [3:0] {
        MODE_NORMAL = 4'h0,
        MODE_PIN = 4'h1,
        MODE_CYCLIC = 4'h4,
        MODE_CYC_PIN = 4'h5,
        MODE_SUPPORT = 4'h7,
        MODE_SYNC_CYC = 4'h8
    } sleep_mode_t;

    // Gray order along ACTIVE, DRAIN, SLEEP.
    typedef enum logic [1:0] {
        ST_ACTIVE = 2'h0,
        ST_DRAIN = 2'h1,
        ST_SLEEP = 2'h3
    } pwr_state_t;

endpackage
`default_nettype wire

// File: hw/slp_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous pins; output follows once stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module slp_pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Pins in, filtered levels out
    input wire logic [W-1:0] i_pin,
    output logic [W-1:0] o_level
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] lvl_q;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    s1_q[g] <= 1'b0;
                    s2_q[g] <= 1'b0;
                    s3_q[g] <= 1'b0;
                    lvl_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= i_pin[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    if (s2_q[g] == s3_q[g]) begin
                        lvl_q[g] <= s3_q[g];
                    end
                end
            end
        end
    endgenerate

    assign o_level = lvl_q;

endmodule // slp_pin_sync
`default_nettype wire

// File: dv/slp_host_model.sv
// Host model that drives the sleep request pin of the scheduler.
// Assumes the bench commands the wanted level; the pin moves after a rise.
`timescale 1ns/100ps
`default_nettype none
module slp_host_model (
    // Clock and command
    input wire logic i_clk,
    input wire logic i_want_sleep,
    // Pin
    output logic o_sleep_request_pin
);
    // The host drives the pin high to ask for sleep, low to wake.
    always @(posedge i_clk) begin
        o_sleep_request_pin <= i_want_sleep;
    end
endmodule // slp_host_model
`default_nettype wire

// File: dv/sleep_mode_and_sample_scheduler_test.sv
// Self-checking bench for the sleep and sample scheduler.
// Assumes a 10-cycle millisecond and the host model on the request pin.
`timescale 1ns/100ps
`default_nettype none
`include "slp_sched_regs.svh"
module sleep_mode_and_sample_scheduler_test;
logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
logic [7:0] paddr = 8'h00;
logic [31:0] pwdata = 32'h0, rd, prdata;
logic want = 1'b0, busy = 1'b0, ser = 1'b0, syn = 1'b0, sfs = 1'b0;
logic srx = 1'b0, err, pready, pslverr, rq, awake, cts_n, sleeping;
logic relay, sync_tx, s_req, s_chg, s_fwd, s_drop;
logic [12:0] dio = 13'h0000;
logic [31:0] n_relay = 32'h0, n_tx = 32'h0, n_req = 32'h0, n_chg = 32'h0;
logic [31:0] n_fwd = 32'h0, n_drop = 32'h0, snap;
logic rf = 1'b0, jreq = 1'b0, rx_en, tx_ok, route_ok, poll;
logic [15:0] ssl = 16'h0000, swk = 16'h0000;
logic [31:0] n_poll = 32'h0, n_slp = 32'h0, n_off = 32'h0, s_slp, s_off;
int bad_count = 0;
int n_compared = 0;
always #2 clk = ~clk;
always @(posedge clk) begin
    n_relay <= n_relay + relay;
    n_tx <= n_tx + sync_tx;
    n_req <= n_req + s_req;
    n_chg <= n_chg + s_chg;
    n_fwd <= n_fwd + s_fwd;
    n_drop <= n_drop + s_drop;
    n_poll <= n_poll + poll;
    n_slp <= n_slp + sleeping;
    n_off <= n_off + !tx_ok;
end
slp_host_model i_slp_host_model (.i_clk(clk), .i_want_sleep(want),
    .o_sleep_request_pin(rq));
slp_sched #(.MS_CYCLES(10)) i_slp_sched (.I_SYS_CLK(clk), .I_SYS_RST(rst),
    .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_SLEEP_REQUEST_PIN(rq), .I_DIO(dio), .O_AWAKE(awake),
    .O_CTS_N(cts_n), .I_BUSY(busy), .I_SER_RX(ser), .I_RF_RX(rf),
    .I_SYNC_RX(syn), .I_SYNC_FROM_SLEEPER(sfs), .I_SYNC_SLEEP_MS(ssl),
    .I_SYNC_WAKE_MS(swk), .I_JOIN_REQ(jreq), .I_SAMPLE_RX(srx),
    .O_SLEEPING(sleeping), .O_RX_EN(rx_en), .O_DATA_TX_OK(tx_ok),
    .O_ROUTE_OK(route_ok), .O_SYNC_TX(sync_tx), .O_SYNC_RELAY(relay),
    .O_SYNC_POLL(poll),
    .O_SAMPLE_REQ(s_req), .O_SAMPLE_CHG(s_chg), .O_SAMPLE_FWD(s_fwd),
    .O_SAMPLE_DROP(s_drop));
////////////////////////////////////////////////////////////////////////
task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
        bad_count++;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
endtask
// Called just after a rising edge; holds the request until pready.
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (k = 0; k < 20; k++) begin
        @(posedge clk);
        if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    // An idle edge keeps a following call from rewriting psel at once.
    @(posedge clk);
    if (k >= 20) begin
        bad_count++;
        $display("[ERR] %0t apb transfer timed out", $time);
        stop_test();
    end
endtask
// Sleeping must reach lvl no sooner than lo and before hi cycles.
task automatic wait_slp(input logic lvl, input int lo, input int hi);
    int k;
    for (k = 0; k < hi && sleeping !== lvl; k++) @(negedge clk);
    chk({31'h0, k >= lo && k < hi}, 32'h1);
    @(posedge clk);
    if (k >= hi) stop_test();
endtask
////////////////////////////////////////////////////////////////////////
initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, `SLP_ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `SLP_ADDR_WAKE, 32'h0);
    chk(rd, 32'h64);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("reset test done");
    // Busy holds off sleep, so a transfer in flight is not cut.
    busy <= 1'b1;
    want <= 1'b1;
    apb(1'b1, `SLP_ADDR_CTRL, 32'h11);
    repeat (20) @(posedge clk);
    chk({31'h0, sleeping}, 32'h0);
    busy <= 1'b0;
    wait_slp(1'b1, 0, 10);
    chk({31'h0, cts_n}, 32'h1);
    want <= 1'b0;
    wait_slp(1'b0, 0, 12);
    chk({31'h0, cts_n}, 32'h0);
    $display("pin sleep test done");
    apb(1'b1, `SLP_ADDR_WAKE, 32'h2);
    apb(1'b1, `SLP_ADDR_SLEEP, 32'h3);
    ser <= 1'b1;
    apb(1'b1, `SLP_ADDR_CTRL, 32'h14);
    repeat (40) @(posedge clk);
    chk({31'h0, sleeping}, 32'h0);
    ser <= 1'b0;
    rf <= 1'b1;
    repeat (20) @(posedge clk);
    chk({31'h0, sleeping}, 32'h0);
    rf <= 1'b0;
    wait_slp(1'b1, 10, 40);
    chk({31'h0, awake}, 32'h0);
    wait_slp(1'b0, 20, 50);
    chk({31'h0, awake}, 32'h1);
    wait_slp(1'b1, 0, 4);
    $display("cyclic test done");
    want <= 1'b1;
    apb(1'b1, `SLP_ADDR_CTRL, 32'h5);
    wait_slp(1'b0, 0, 50);
    wait_slp(1'b1, 0, 50);
    want <= 1'b0;
    wait_slp(1'b0, 0, 12);
    repeat (60) @(posedge clk);
    chk({31'h0, sleeping}, 32'h0);
    $display("pin wake test done");
    apb(1'b1, `SLP_ADDR_CTRL, 32'h0);
    syn <= 1'b1;
    sfs <= 1'b1;
    @(posedge clk);
    sfs <= 1'b0;
    @(posedge clk);
    syn <= 1'b0;
    repeat (3) @(posedge clk);
    chk(n_relay, 32'h1);
    chk(n_tx, 32'h0);
    snap = n_req;
    apb(1'b1, `SLP_ADDR_IVAL, 32'h2);
    repeat (100) @(posedge clk);
    apb(1'b1, `SLP_ADDR_IVAL, 32'h0);
    // A pulse launched at the write edge reaches the counter later.
    repeat (3) @(posedge clk);
    snap = n_req - snap;
    chk({31'h0, snap >= 4 && snap <= 6}, 32'h1);
    snap = n_req;
    repeat (100) @(posedge clk);
    chk(n_req, snap);
    apb(1'b1, `SLP_ADDR_MASK, 32'h1);
    dio <= 13'h0002;
    repeat (10) @(posedge clk);
    chk(n_chg, 32'h0);
    dio <= 13'h0003;
    repeat (10) @(posedge clk);
    chk(n_chg, 32'h1);
    srx <= 1'b1;
    @(posedge clk);
    srx <= 1'b0;
    apb(1'b1, `SLP_ADDR_CTRL, 32'h40);
    srx <= 1'b1;
    @(posedge clk);
    srx <= 1'b0;
    repeat (3) @(posedge clk);
    chk(n_drop, 32'h1);
    chk(n_fwd, 32'h1);
    $display("sync and sample test done");
    // Leaving the sync modes drops the sync, so mode 8 starts unsynced.
    apb(1'b1, `SLP_ADDR_CTRL, 32'h1);
    apb(1'b1, `SLP_ADDR_CTRL, 32'h38);
    wait_slp(1'b1, 0, 80);
    snap = n_poll;
    chk({31'h0, rx_en}, 32'h0);
    chk({31'h0, route_ok}, 32'h0);
    chk({30'h0, cts_n, awake}, 32'h2);
    wait_slp(1'b0, 0, 80);
    @(posedge clk);
    chk(n_poll - snap, 32'h1);
    chk({30'h0, cts_n, awake}, 32'h1);
    ssl <= 16'h0006;
    swk <= 16'h0003;
    syn <= 1'b1;
    @(posedge clk);
    syn <= 1'b0;
    apb(1'b0, `SLP_ADDR_NSLP, 32'h0);
    chk(rd, 32'h6);
    apb(1'b0, `SLP_ADDR_NWAK, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, `SLP_ADDR_STAT, 32'h0);
    chk(rd, 32'h3);
    wait_slp(1'b1, 0, 60);
    wait_slp(1'b0, 45, 70);
    apb(1'b1, `SLP_ADDR_CTRL, 32'hB8);
    wait_slp(1'b1, 0, 60);
    snap = n_tx;
    wait_slp(1'b0, 45, 70);
    @(posedge clk);
    chk(n_tx - snap, 32'h1);
    apb(1'b1, `SLP_ADDR_CTRL, 32'h7);
    snap = n_tx;
    s_slp = n_slp;
    s_off = n_off;
    jreq <= 1'b1;
    @(posedge clk);
    jreq <= 1'b0;
    repeat (100) @(posedge clk);
    chk(n_tx - snap, 32'h1);
    chk(n_slp - s_slp, 32'h0);
    chk({31'h0, n_off != s_off}, 32'h1);
    $display("sync mode test done");
    stop_test();
end
endmodule // sleep_mode_and_sample_scheduler_test
`default_nettype wire
